/* b4sp_top.sv */
/*
 * Device side of a burst-of-four separate-I/O SRAM: command capture, arbitration,
 * double-edge write capture with lane masks, array, forwarding and read launch.
 * Assumes the controller drives all link pins synchronous to k_clk, uses the falling
 * edge of k_clk as the K# rise, and joins q_k/q_kn into one pin by clock phase.
 */
`timescale 1ns/1ps
module b4sp_top #(
    parameter int DATA_W = b4sp_pkg::DATA_W,
    parameter int ADDR_W = b4sp_pkg::ADDR_W
) (
    // system clock side
    input  wire logic                clk,
    input  wire logic                resetn,
    output logic                     read_busy,
    output logic                     write_busy,
    // link clock and command pins
    input  wire logic                k_clk,
    input  wire logic [ADDR_W-1:0]   addr,
    input  wire logic                read_port_select_n,
    input  wire logic                write_port_select_n,
    // write data pins
    input  wire logic [DATA_W/9-1:0] lane_write_select_n,
    input  wire logic [DATA_W-1:0]   wdata,
    // read data, K rise half and K# rise half
    output logic      [DATA_W-1:0]   q_k,
    output logic                     q_k_oe,
    output logic      [DATA_W-1:0]   q_kn,
    output logic                     q_kn_oe
);

    localparam int LANES  = DATA_W / b4sp_pkg::LANE_W;
    localparam int LINE_W = DATA_W * b4sp_pkg::BURST;

    // only the two documented organisations are served
    if ((DATA_W % b4sp_pkg::LANE_W != 0) || ((LANES != 2) && (LANES != 4)))
    begin : g_bad_width
        $error("b4sp_top: DATA_W must be 18 or 36");
    end
    if (LANES != DATA_W / 9)
    begin : g_bad_lane
        $error("b4sp_top: lane width mismatch");
    end

    // merge one word into its old content, lane by lane
    function automatic logic [DATA_W-1:0] lane_merge(
        input logic [DATA_W-1:0] old_w,
        input logic [DATA_W-1:0] new_w,
        input logic [LANES-1:0]  sel_n
    );
        logic [DATA_W-1:0] r;
        r = old_w;
        for (int i = 0; i < LANES; i++)
        begin
            if (!sel_n[i])
            begin
                r[i*b4sp_pkg::LANE_W +: b4sp_pkg::LANE_W] =
                    new_w[i*b4sp_pkg::LANE_W +: b4sp_pkg::LANE_W];
            end
        end
        return r;
    endfunction

    // reset crossing into the link domain and status back
    logic                 lrst_n;
    logic                 lrst;
    b4sp_pkg::b4sp_stat_t stat_k;
    b4sp_pkg::b4sp_stat_t stat_c;

    b4sp_sync #(
        .WIDTH (1)
    ) u_rst_sync (
        .clk   (k_clk),
        .rst_n (1'b1),
        .d     (resetn),
        .q     (lrst_n)
    );

    b4sp_sync #(
        .WIDTH (b4sp_pkg::STAT_W)
    ) u_stat_sync (
        .clk   (clk),
        .rst_n (resetn),
        .d     (stat_k),
        .q     (stat_c)
    );

    assign lrst       = !lrst_n;
    assign read_busy  = stat_c.read_busy;
    assign write_busy = stat_c.write_busy;

    // link-domain state
    logic [b4sp_pkg::RD_STAGES-1:0] rd;
    logic [b4sp_pkg::WR_STAGES-1:0] wr;
    logic [ADDR_W-1:0]              raddr;
    logic [ADDR_W-1:0]              waddr;
    logic [ADDR_W-1:0]              waddr_c;
    logic [DATA_W-1:0]              wbuf0;
    logic [DATA_W-1:0]              wbuf1;
    logic [DATA_W-1:0]              wbuf2;
    logic [LANES-1:0]               wbe0;
    logic [LANES-1:0]               wbe1;
    logic [LANES-1:0]               wbe2;
    logic [DATA_W-1:0]              neg_d;
    logic [LANES-1:0]               neg_be;
    logic [LINE_W-1:0]              rbuf;
    logic [LINE_W-1:0]              mem [0:(1<<ADDR_W)-1];

    // request decode and arbitration
    wire rd_req   = !read_port_select_n && !rd[0];
    wire wr_req   = !write_port_select_n && !wr[0];
    wire start_rd = rd_req;
    wire start_wr = wr_req && !rd_req;
    wire fetch    = rd[b4sp_pkg::RD_FETCH];
    wire commit   = wr[b4sp_pkg::WR_COMMIT];

    // line to commit: three buffered words plus the last K# word
    wire [LINE_W-1:0] old_line = mem[waddr_c];
    wire [LINE_W-1:0] new_line;
    wire [DATA_W-1:0] cw [0:3];
    wire [LANES-1:0]  cbe [0:3];

    assign cw[0]  = wbuf0;
    assign cw[1]  = wbuf1;
    assign cw[2]  = wbuf2;
    assign cw[3]  = neg_d;
    assign cbe[0] = wbe0;
    assign cbe[1] = wbe1;
    assign cbe[2] = wbe2;
    assign cbe[3] = neg_be;

    // word k sits at burst position A+k of the line
    for (genvar k = 0; k < b4sp_pkg::BURST; k++)
    begin : g_word
        assign new_line[k*DATA_W +: DATA_W] =
            lane_merge(old_line[k*DATA_W +: DATA_W], cw[k], cbe[k]);
    end

    // forwarding covers a commit landing on the same rise as the fetch
    wire              fwd      = commit && (waddr_c == raddr);
    wire [LINE_W-1:0] rd_line  = fwd ? new_line : mem[raddr];
    wire [DATA_W-1:0] rd_word0 = rbuf[0*DATA_W +: DATA_W];
    wire [DATA_W-1:0] rd_word1 = rbuf[1*DATA_W +: DATA_W];
    wire [DATA_W-1:0] rd_word2 = rbuf[2*DATA_W +: DATA_W];
    wire [DATA_W-1:0] rd_word3 = rbuf[3*DATA_W +: DATA_W];
    wire              rd_out   = rd[b4sp_pkg::RD_LAUNCH] || rd[b4sp_pkg::RD_LAST];

    // start pipelines; a stopped k_clk just freezes everything here
    always_ff @(posedge k_clk)
    begin
        if (lrst)
        begin
            rd     <= '0;
            wr     <= '0;
            stat_k <= '0;
        end
        else
        begin
            rd     <= {rd[b4sp_pkg::RD_STAGES-2:0], start_rd};
            wr     <= {wr[b4sp_pkg::WR_STAGES-2:0], start_wr};
            stat_k <= '{read_busy: (|rd) || start_rd, write_busy: (|wr) || start_wr};
        end
    end

    // addresses; the commit copy frees waddr for a write two rises later
    always_ff @(posedge k_clk)
    begin
        if (start_rd)
        begin
            raddr <= addr;
        end
        if (start_wr)
        begin
            waddr <= addr;
        end
        if (wr[b4sp_pkg::WR_WORD2])
        begin
            waddr_c <= waddr;
        end
    end

    // K-rise write words plus the first K# word, each with its own lane mask
    always_ff @(posedge k_clk)
    begin
        if (wr[b4sp_pkg::WR_WORD0])
        begin
            wbuf0 <= wdata;
            wbe0  <= lane_write_select_n;
        end
        if (wr[b4sp_pkg::WR_WORD2])
        begin
            wbuf1 <= neg_d;
            wbe1  <= neg_be;
            wbuf2 <= wdata;
            wbe2  <= lane_write_select_n;
        end
    end

    // K#-rise capture runs on every fall of k_clk; only write slots are used
    always_ff @(negedge k_clk)
    begin
        neg_d  <= wdata;
        neg_be <= lane_write_select_n;
    end

    // one whole-line write per burst keeps the array single ported
    always_ff @(posedge k_clk)
    begin
        if (commit)
        begin
            mem[waddr_c] <= new_line;
        end
    end

    // fetch two rises after the address, in time for the K# launch
    always_ff @(posedge k_clk)
    begin
        if (fetch)
        begin
            rbuf <= rd_line;
        end
    end

    // K-rise half of the read burst: words A+1 and A+3
    always_ff @(posedge k_clk)
    begin
        if (lrst)
        begin
            q_k    <= '0;
            q_k_oe <= 1'b0;
        end
        else
        begin
            q_k_oe <= rd_out;
            if (rd[b4sp_pkg::RD_LAUNCH])
            begin
                q_k <= rd_word1;
            end
            else if (rd[b4sp_pkg::RD_LAST])
            begin
                q_k <= rd_word3;
            end
        end
    end

    // K#-rise half: word A at t+2.5 and A+2 at t+3.5; released after the burst
    always_ff @(negedge k_clk)
    begin
        if (lrst)
        begin
            q_kn    <= '0;
            q_kn_oe <= 1'b0;
        end
        else
        begin
            q_kn_oe <= rd_out;
            if (rd[b4sp_pkg::RD_LAUNCH])
            begin
                q_kn <= rd_word0;
            end
            else if (rd[b4sp_pkg::RD_LAST])
            begin
                q_kn <= rd_word2;
            end
        end
    end

    // checks on the K-rise side
    default clocking cb @(posedge k_clk);
    endclocking
    default disable iff (lrst);

    sequence s_wr_start;
        start_wr;
    endsequence

    sequence s_wr_words;
        wr[0] ##1 wr[1] ##1 commit;
    endsequence

    sequence s_rd_start;
        start_rd;
    endsequence

    sequence s_rd_launch;
        q_k_oe [*2];
    endsequence

    wire idle_now = read_port_select_n && write_port_select_n && (rd == '0) && (wr == '0);

    rd_latency_a: assert property (s_rd_start |-> ##4 s_rd_launch)
        else $error("read burst not launched on time");

    wr_commit_a: assert property (s_wr_start |=> s_wr_words)
        else $error("write burst not committed at t+3");

    rd_spacing_a: assert property (start_rd |=> !start_rd)
        else $error("read started on consecutive rises");

    wr_spacing_a: assert property (start_wr |=> !start_wr)
        else $error("write started on consecutive rises");

    arb_read_a: assert property ((!read_port_select_n && !write_port_select_n && !rd[0])
        |-> (start_rd && !start_wr))
        else $error("read did not win arbitration");

    arb_write_a: assert property ((!write_port_select_n && rd[0] && !wr[0]) |-> start_wr)
        else $error("write did not win after a read");

    nop_idle_a: assert property (idle_now |=> (!q_k_oe && !rd[0] && !wr[0]))
        else $error("activity without a request");

    word_order_a: assert property (rd[b4sp_pkg::RD_LAUNCH] |=> (q_k == $past(rd_word1)))
        else $error("burst word out of order");

    lane_keep_a: assert property ((commit && (&wbe2))
        |-> (new_line[2*DATA_W +: DATA_W] == old_line[2*DATA_W +: DATA_W]))
        else $error("masked lanes were altered");

    lane_write_a: assert property ((commit && (wbe2 == '0))
        |-> (new_line[2*DATA_W +: DATA_W] == wbuf2))
        else $error("selected lanes not written");

    fwd_new_a: assert property ((fetch && fwd) |=> (rbuf == $past(new_line)))
        else $error("read missed a pending write");

endmodule // b4sp_top

/* b4sp_pkg.sv */
/*
 * Shared constants and carrier types for the burst-of-four separate-I/O SRAM port.
 * Assumes one link clock K that drives all link pins, with K# taken as K's falling edge.
 */
package b4sp_pkg;

    // organisation
    localparam int LANE_W    = 9;
    localparam int DATA_W    = 18;
    localparam int ADDR_W    = 19;
    localparam int BURST     = 4;

    // pipeline stage indices, counted in K cycles after the start rise
    localparam int RD_FETCH  = 1;
    localparam int RD_LAUNCH = 2;
    localparam int RD_LAST   = 3;
    localparam int WR_WORD0  = 0;
    localparam int WR_WORD2  = 1;
    localparam int WR_COMMIT = 2;
    localparam int RD_STAGES = 4;
    localparam int WR_STAGES = 3;

    // activity seen from the system clock side
    typedef struct packed {
        logic read_busy;
        logic write_busy;
    } b4sp_stat_t;

    localparam int STAT_W    = 2;

endpackage

/* b4sp_sync.sv */
/*
 * Two flip-flop level synchroniser, any width.
 * Assumes each bit is a level that may be sampled independently of its neighbours.
 */
`timescale 1ns/1ps
module b4sp_sync #(
    parameter int WIDTH = 1
) (
    // destination clock and synchronous reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // level in, level out
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta <= '0;
            q    <= '0;
        end
        else
        begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule // b4sp_sync

/* b4sp_ctl_model.sv */
/*
 * Controller model for the burst-of-four sram port: drives the link pins just
 * after k_clk edges and logs every read word with the edge index it came on.
 * Assumes k_clk runs, or is parked high between steps, and the read pin joins
 * q_k/q_kn by clock phase.
 */
`timescale 1ns/1ps
module b4sp_ctl_model (
    // link clock
    input  wire logic        k_clk,
    // command and write pins
    output logic [5:0]       addr,
    output logic             read_port_select_n,
    output logic             write_port_select_n,
    output logic [1:0]       lane_write_select_n,
    output logic [17:0]      wdata,
    // read data halves
    input  wire logic [17:0] q_k,
    input  wire logic        q_k_oe,
    input  wire logic [17:0] q_kn,
    input  wire logic        q_kn_oe
);
    logic [17:0] pin_q;
    logic [17:0] rq_word [$];
    int          rq_edge [$];
    int          edge_n = 0;

    // one pin, shared by phase; released halves float
    assign pin_q = k_clk ? (q_k_oe ? q_k : {18{1'bZ}}) : (q_kn_oe ? q_kn : {18{1'bZ}});

    // idle levels at time zero
    initial
    begin
        addr = 6'h00;
        read_port_select_n = 1'b1;
        write_port_select_n = 1'b1;
        lane_write_select_n = 2'h3;
        wdata = 18'h00000;
    end

    // sample 1 ns after each edge so the launching register has settled
    always @(k_clk)
    begin
        edge_n = edge_n + 1;
        #1;
        if (pin_q !== {18{1'bZ}})
        begin
            rq_word.push_back(pin_q);
            rq_edge.push_back(edge_n);
        end
    end

    // one k cycle: command for the next rise, data for that rise and the fall after
    task automatic step(input logic rn, input logic wn, input logic [5:0] a,
                        input logic dv, input logic [17:0] d0, input logic [1:0] m0,
                        input logic [17:0] d1, input logic [1:0] m1, output int ce);
        @(negedge k_clk);
        #1;
        read_port_select_n = rn;
        write_port_select_n = wn;
        addr = (rn & wn) ? ~addr : a; // unused bus keeps moving
        wdata = dv ? d0 : ~wdata;
        lane_write_select_n = dv ? m0 : ~lane_write_select_n;
        @(posedge k_clk);
        #1;
        ce = edge_n;
        read_port_select_n = 1'b1;
        write_port_select_n = 1'b1;
        addr = ~addr;
        wdata = dv ? d1 : ~wdata;
        lane_write_select_n = dv ? m1 : ~lane_write_select_n;
    endtask
endmodule // b4sp_ctl_model

/* test_burst4_sram_port_byte_write.sv */
/*
 * Self-checking bench for the burst-of-four sram port with a 6-bit line address.
 * Assumes the controller model drives all link pins; the bench owns clocks and reset.
 */
`timescale 1ns/1ps
module test_burst4_sram_port_byte_write;
    logic        clk = 1'b0;
    logic        k_clk = 1'b0;
    logic        k_run = 1'b1;
    logic        resetn = 1'b0;
    logic        read_busy, write_busy, rps_n, wps_n, q_k_oe, q_kn_oe;
    logic [5:0]  addr;
    logic [1:0]  lane_n;
    logic [17:0] wdata, q_k, q_kn;
    logic [17:0] exp_mem [64][4];
    int          fail_count = 0;
    int          check_count = 0;
    int          cyc_n = 0;
    int          last_ce, c0, c1, c2;

    b4sp_top #(.DATA_W(18), .ADDR_W(6)) u_dut (.clk(clk), .resetn(resetn),
        .read_busy(read_busy), .write_busy(write_busy), .k_clk(k_clk), .addr(addr),
        .read_port_select_n(rps_n), .write_port_select_n(wps_n),
        .lane_write_select_n(lane_n), .wdata(wdata), .q_k(q_k), .q_k_oe(q_k_oe),
        .q_kn(q_kn), .q_kn_oe(q_kn_oe));
    b4sp_ctl_model u_ctl (.k_clk(k_clk), .addr(addr), .read_port_select_n(rps_n),
        .write_port_select_n(wps_n), .lane_write_select_n(lane_n), .wdata(wdata),
        .q_k(q_k), .q_k_oe(q_k_oe), .q_kn(q_kn), .q_kn_oe(q_kn_oe));

    // system clock 40 ns; link clock 15 ns with an unrelated phase
    initial
    begin
        forever #20 clk = ~clk;
    end
    initial
    begin
        #3.3;
        forever
        begin
            #7.5;
            if (k_run || !k_clk)
                k_clk = ~k_clk; // a stopped link clock parks high
        end
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // hang guard: the whole run needs well under a hundred clk cycles
    always @(posedge clk)
    begin
        cyc_n++;
        if (cyc_n == 3000)
        begin
            fail_count++;
            $display("ERROR t=%0t run did not finish", $time);
            wrap_up();
        end
    end

    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic void put(input logic [5:0] a, input logic [17:0] b,
                                input logic [7:0] m);
        logic [17:0] d;
        for (int k = 0; k < 4; k++)
        begin
            d = b + 18'(k);
            for (int l = 0; l < 2; l++)
                if (!m[2*k+l]) exp_mem[a][k][9*l +: 9] = d[9*l +: 9];
        end
    endfunction

    task automatic st(input logic rn, input logic wn, input logic [5:0] a, input logic dv,
                      input logic [17:0] d0, input logic [17:0] d1,
                      input logic [1:0] m0, input logic [1:0] m1);
        u_ctl.step(rn, wn, a, dv, d0, m0, d1, m1, last_ce);
    endtask

    task automatic idle(input int n);
        repeat (n) st(1'b1, 1'b1, 6'h00, 1'b0, 18'h00000, 18'h00000, 2'h3, 2'h3);
    endtask

    // write burst at t; rn1/wn1/a1 is a request placed on the rise t+1
    task automatic wr(input logic [5:0] a, input logic [17:0] b, input logic [7:0] m,
                      input logic rn1, input logic wn1, input logic [5:0] a1,
                      output int rce);
        st(1'b1, 1'b0, a, 1'b0, 18'h00000, 18'h00000, 2'h3, 2'h3);
        st(rn1, wn1, a1, 1'b1, b, b + 18'h00001, m[1:0], m[3:2]);
        rce = last_ce;
        st(1'b1, 1'b1, a, 1'b1, b + 18'h00002, b + 18'h00003, m[5:4], m[7:6]);
        put(a, b, m);
    endtask

    // four words of line a, first on the fall of t+2, one per edge after
    task automatic burst(input logic [5:0] a, input int ce);
        for (int k = 0; k < 4; k++)
        begin
            chk(u_ctl.rq_word.pop_front(), exp_mem[a][k]);
            chk(18'(u_ctl.rq_edge.pop_front()), 18'(ce + 5 + k));
        end
    endtask

    task automatic t_idle;
        idle(4);
        chk(18'(q_k_oe), 18'h00000);
        chk(18'(q_kn_oe), 18'h00000);
        chk(18'({read_busy, write_busy}), 18'h00000);
        chk(18'(u_ctl.rq_word.size()), 18'h00000);
        $display("idle test done");
    endtask

    task automatic t_fwd;
        wr(6'h05, 18'h01000, 8'h00, 1'b0, 1'b1, 6'h05, c0);
        idle(6);
        burst(6'h05, c0);
        $display("forwarding test done");
    endtask

    task automatic t_lanes;
        wr(6'h09, 18'h3FFF0, 8'h00, 1'b1, 1'b1, 6'h00, c0);
        wr(6'h09, 18'h0A5A0, 8'h39, 1'b1, 1'b1, 6'h00, c0);
        st(1'b0, 1'b1, 6'h09, 1'b0, 18'h00000, 18'h00000, 2'h3, 2'h3);
        c0 = last_ce;
        idle(6);
        burst(6'h09, c0);
        $display("lane test done");
    endtask

    task automatic t_twice;
        wr(6'h0C, 18'h22220, 8'h00, 1'b1, 1'b1, 6'h00, c0);
        wr(6'h07, 18'h07770, 8'h00, 1'b1, 1'b0, 6'h0C, c0);
        st(1'b0, 1'b1, 6'h0C, 1'b0, 18'h00000, 18'h00000, 2'h3, 2'h3);
        c0 = last_ce;
        st(1'b0, 1'b1, 6'h07, 1'b0, 18'h00000, 18'h00000, 2'h3, 2'h3);
        st(1'b0, 1'b1, 6'h07, 1'b0, 18'h00000, 18'h00000, 2'h3, 2'h3);
        c1 = last_ce;
        idle(6);
        burst(6'h0C, c0);
        burst(6'h07, c1);
        chk(18'(u_ctl.rq_word.size()), 18'h00000);
        $display("back to back test done");
    endtask

    task automatic t_both;
        wr(6'h14, 18'h11110, 8'h00, 1'b1, 1'b1, 6'h00, c0);
        st(1'b0, 1'b0, 6'h14, 1'b0, 18'h00000, 18'h00000, 2'h3, 2'h3);
        c0 = last_ce;
        st(1'b0, 1'b0, 6'h15, 1'b0, 18'h00000, 18'h00000, 2'h3, 2'h3);
        st(1'b1, 1'b1, 6'h00, 1'b1, 18'h15150, 18'h15151, 2'h0, 2'h0);
        st(1'b0, 1'b1, 6'h14, 1'b1, 18'h15152, 18'h15153, 2'h0, 2'h0);
        c1 = last_ce;
        put(6'h15, 18'h15150, 8'h00);
        idle(1);
        st(1'b0, 1'b1, 6'h15, 1'b0, 18'h00000, 18'h00000, 2'h3, 2'h3);
        c2 = last_ce;
        idle(6);
        burst(6'h14, c0);
        burst(6'h14, c1);
        burst(6'h15, c2);
        $display("arbitration test done");
    endtask

    // link clock parked high in mid burst: outputs and status must hold
    task automatic t_stop;
        st(1'b0, 1'b1, 6'h0C, 1'b0, 18'h00000, 18'h00000, 2'h3, 2'h3);
        c0 = last_ce;
        idle(3);
        k_run = 1'b0;
        #200;
        chk(18'({q_k_oe, read_busy}), 18'h00003);
        chk(q_k, exp_mem[6'h0C][1]);
        k_run = 1'b1;
        idle(6);
        burst(6'h0C, c0);
        $display("clock stop test done");
    endtask

    // reset is driven on the falling edge of clk
    initial
    begin
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        repeat (3) @(negedge clk);
        u_ctl.rq_word.delete();
        u_ctl.rq_edge.delete();
        t_idle();
        t_fwd();
        t_lanes();
        t_twice();
        t_stop();
        t_both();
        wrap_up();
    end
endmodule // test_burst4_sram_port_byte_write
